// [design/spcph_pkg.sv]
// spcph_pkg: constants, types and frame states of the programmed clock and power hold block
// assumes a 20 MHz system clock; every timing count is derived from SYS_CLK_HZ
package spcph_pkg;

  // clock rates in Hz
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned STEP_HZ = 1_200;
  localparam int unsigned MAX_HZ = 32_769_000;
  localparam int unsigned DEF_HZ = 3_686_400;

  // frequency word counts steps of STEP_HZ, nco increment is word times 2*STEP_HZ
  typedef logic [14:0] spcph_fword_t;
  typedef logic [26:0] spcph_inc_t;

  localparam spcph_fword_t FW_MAX = 15'(MAX_HZ / STEP_HZ);
  localparam spcph_fword_t FW_DEF = 15'(DEF_HZ / STEP_HZ);
  // the square wave toggles at most once per system clock
  localparam spcph_fword_t FW_PROD_MAX = 15'(SYS_CLK_HZ / (2 * STEP_HZ));
  localparam spcph_inc_t NCO_MOD = 27'(SYS_CLK_HZ);
  localparam spcph_inc_t NCO_STEP = 27'(2 * STEP_HZ);
  localparam spcph_inc_t INC_DEF = 27'(DEF_HZ * 2);

  // reference is declared lost after this long without an edge
  localparam int unsigned REF_LOSS_NS = 1_000;
  localparam logic [7:0] REF_LOSS_CYC = 8'((REF_LOSS_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1_000);

  // serial frame
  localparam logic [4:0] FRAME_MAX_BYTES = 5'h13;
  localparam int unsigned FRAME_MAX_BITS = 152;
  localparam logic [4:0] IDX_CLK_HI = 5'h01;
  localparam logic [4:0] IDX_CLK_LO = 5'h02;
  localparam logic [4:0] IDX_GCB = 5'h03;

  // general control outputs
  localparam int unsigned GCB_W = 6;
  localparam int unsigned GCB_HOLD_BIT = 2;
  localparam logic [5:0] GCB_RST = 6'h04;

  // synchroniser lanes
  localparam int unsigned SY_SCLK = 0;
  localparam int unsigned SY_MOSI = 1;
  localparam int unsigned SY_CS = 2;
  localparam int unsigned SY_REF = 3;
  localparam int unsigned SY_IGN = 4;
  localparam logic [4:0] SY_RST = 5'h04;

  // status byte returned on the slave data line
  localparam int unsigned ST_REF = 7;
  localparam int unsigned ST_FALLBACK = 6;
  localparam int unsigned ST_OVR = 5;
  localparam int unsigned ST_IGN = 4;

  // byte buffer
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    SPCPH_IDLE = 2'b00,
    SPCPH_ADDR = 2'b01,
    SPCPH_DATA = 2'b10,
    SPCPH_SKIP = 2'b11
  } spcph_frame_t;

endpackage

// [design/spcph_fifo_if.sv]
// spcph_fifo_if: valid/ready byte path between the frame decoder and its buffer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface spcph_fifo_if #(parameter int W = 8) ();
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  modport src (output in_valid, output in_data, output out_ready,
               input in_ready, input out_valid, input out_data);
  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data);
endinterface
`default_nettype wire

// [design/spcph_fifo.sv]
// spcph_fifo: synchronous first-in first-out buffer, width and depth as parameters
// assumes DEPTH is a power of two and one clock domain
`timescale 1ns/1ps
`default_nettype none
module spcph_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  spcph_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty without a counter
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign f.in_ready = ~full;
  assign f.out_valid = ~empty;
  assign f.out_data = mem[rd_q[AW-1:0]];
  assign push = f.in_valid & ~full;
  assign pop = f.out_ready & ~empty;

  // storage carries no reset, only the pointers need one
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= f.in_data;
    end
  end

  // write pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [design/spcph_top.sv]
// spcph_top: processor clock synthesiser, serial programming slave and general control outputs
// assumes all pins are asynchronous to sys_clk and the serial clock is well below sys_clk / 6
`timescale 1ns/1ps
`default_nettype none
module spcph_top
  import spcph_pkg::*;
#(
  parameter logic [7:0] DEV_ADDR = 8'h5A
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ref_clk_in,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic shared_slave_select_n,
  input wire logic ignition_off_sense,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  output logic proc_clk_out,
  output logic [GCB_W-1:0] general_control_outputs,
  output logic supply_keep_output,
  output logic ref_present,
  output logic clk_fallback,
  output logic frame_overrun,
  output logic cfg_applied
);

  // frequency word is usable when non-zero, in range and within what the nco can toggle
  function automatic logic fw_producible(input spcph_fword_t fw);
    fw_producible = (fw != 15'h0000) && (fw <= FW_MAX) && (fw <= FW_PROD_MAX);
  endfunction

  function automatic spcph_inc_t nco_inc(input spcph_fword_t fw);
    nco_inc = 27'(fw) * NCO_STEP;
  endfunction
  logic [4:0] sy1_q, sy2_q, sy3_q, filt_q, prev_q;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, in_frame, mosi_f, ref_edge;
  spcph_frame_t state_q;
  logic [2:0] bit_cnt_q;
  logic [4:0] byte_cnt_q, drain_idx_q;
  logic [7:0] shift_q, byte_val, push_data_q, stg_hi_q, stg_lo_q, stg_gcb_q, ref_idle_q, miso_sh_q, status;
  logic byte_done, addr_hit, push_valid_q, overrun_q, commit_pend_q, apply_now, pop, miso_fresh_q;
  logic got_hi_q, got_lo_q, got_gcb_q, req_ok, fallback_q, cfg_applied_q, cfg_seen_q, ref_ok_q, tog, pclk_q;
  spcph_fword_t req_fw, fw_sel_q;
  logic [GCB_W-1:0] gcb_q;
  spcph_inc_t acc_q, inc_q;
  logic [27:0] nco_sum;
  spcph_fifo_if #(.W(FIFO_W)) fq ();
  spcph_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .f(fq.fifo)
  );
  // three-stage synchroniser on every pin; stages two and three both feed the filter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sy1_q <= SY_RST;
      sy2_q <= SY_RST;
      sy3_q <= SY_RST;
    end else begin
      sy1_q <= {ignition_off_sense, ref_clk_in, shared_slave_select_n, spi_mosi, spi_sclk};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  // a lane changes only once stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      filt_q <= SY_RST;
      prev_q <= SY_RST;
    end else begin
      filt_q <= (filt_q & (sy2_q ^ sy3_q)) | (sy2_q & ~(sy2_q ^ sy3_q));
      prev_q <= filt_q;
    end
  end

  assign sclk_rise = filt_q[SY_SCLK] & ~prev_q[SY_SCLK];
  assign sclk_fall = ~filt_q[SY_SCLK] & prev_q[SY_SCLK];
  assign cs_fall = ~filt_q[SY_CS] & prev_q[SY_CS];
  assign cs_rise = filt_q[SY_CS] & ~prev_q[SY_CS];
  assign in_frame = ~filt_q[SY_CS];
  assign mosi_f = filt_q[SY_MOSI];
  assign ref_edge = filt_q[SY_REF] ^ prev_q[SY_REF];

  // data is sampled on the serial clock rising edge, msb first
  assign byte_done = sclk_rise & in_frame & (bit_cnt_q == 3'h7);
  assign byte_val = {shift_q[6:0], mosi_f};
  assign addr_hit = (byte_val == DEV_ADDR);

  // frame state: the first byte is the address, a mismatch skips to chip select release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= SPCPH_IDLE;
    end else if (cs_fall) begin
      state_q <= SPCPH_ADDR;
    end else if (cs_rise) begin
      state_q <= SPCPH_IDLE;
    end else if (byte_done && state_q == SPCPH_ADDR) begin
      state_q <= addr_hit ? SPCPH_DATA : SPCPH_SKIP;
    end
  end

  // bit and byte counters; bytes beyond the frame limit are counted no further
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 5'h00;
      shift_q <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 5'h00;
    end else if (sclk_rise && in_frame) begin
      shift_q <= byte_val;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_done && byte_cnt_q < FRAME_MAX_BYTES) begin
        byte_cnt_q <= byte_cnt_q + 5'h01;
      end
    end
  end

  // data bytes of a matched frame go into the buffer, the 19th byte is the last taken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      push_valid_q <= 1'b0;
      push_data_q <= 8'h00;
    end else begin
      push_valid_q <= byte_done && state_q == SPCPH_DATA && byte_cnt_q < FRAME_MAX_BYTES;
      if (byte_done) begin
        push_data_q <= byte_val;
      end
    end
  end

  assign fq.in_valid = push_valid_q;
  assign fq.in_data = push_data_q;

  // a byte the full buffer cannot take is dropped and flagged; the set wins over the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overrun_q <= 1'b0;
    end else if (push_valid_q && !fq.in_ready) begin
      overrun_q <= 1'b1;
    end else if (cs_fall) begin
      overrun_q <= 1'b0;
    end
  end

  // commit waits for the buffer to drain so the last byte of the frame is included
  assign apply_now = commit_pend_q & ~fq.out_valid & ~push_valid_q;
  assign fq.out_ready = ~apply_now;
  assign pop = fq.out_valid & fq.out_ready;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      commit_pend_q <= 1'b0;
    end else if (cs_rise && state_q == SPCPH_DATA) begin
      commit_pend_q <= 1'b1;
    end else if (apply_now) begin
      commit_pend_q <= 1'b0;
    end
  end

  // staging copy is filled while the frame runs and never drives the outputs directly
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      drain_idx_q <= IDX_CLK_HI;
      stg_hi_q <= 8'h00;
      stg_lo_q <= 8'h00;
      stg_gcb_q <= 8'h00;
      got_hi_q <= 1'b0;
      got_lo_q <= 1'b0;
      got_gcb_q <= 1'b0;
    end else if (apply_now) begin
      drain_idx_q <= IDX_CLK_HI;
      got_hi_q <= 1'b0;
      got_lo_q <= 1'b0;
      got_gcb_q <= 1'b0;
    end else if (pop) begin
      if (drain_idx_q < FRAME_MAX_BYTES) begin
        drain_idx_q <= drain_idx_q + 5'h01;
      end
      if (drain_idx_q == IDX_CLK_HI) begin
        stg_hi_q <= fq.out_data;
        got_hi_q <= 1'b1;
      end
      if (drain_idx_q == IDX_CLK_LO) begin
        stg_lo_q <= fq.out_data;
        got_lo_q <= 1'b1;
      end
      if (drain_idx_q == IDX_GCB) begin
        stg_gcb_q <= fq.out_data;
        got_gcb_q <= 1'b1;
      end
    end
  end

  assign req_fw = {stg_hi_q[6:0], stg_lo_q};
  assign req_ok = ~stg_hi_q[7] & fw_producible(req_fw);

  // frequency select; a word that cannot be made falls back to the power-up default
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fw_sel_q <= FW_DEF;
      fallback_q <= 1'b0;
    end else if (apply_now && got_hi_q && got_lo_q) begin
      fw_sel_q <= req_ok ? req_fw : FW_DEF;
      fallback_q <= ~req_ok;
    end
  end

  // general control outputs; power hold comes up set so the supply latches on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gcb_q <= GCB_RST;
    end else if (apply_now && got_gcb_q) begin
      gcb_q <= stg_gcb_q[GCB_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_applied_q <= 1'b0;
      cfg_seen_q <= 1'b0;
    end else begin
      cfg_applied_q <= apply_now;
      cfg_seen_q <= cfg_seen_q | apply_now;
    end
  end

  // reference watchdog: the synthesiser runs only while reference edges keep arriving
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ref_idle_q <= 8'h00;
      ref_ok_q <= 1'b0;
    end else begin
      ref_idle_q <= ref_edge ? 8'h00 : (ref_idle_q < REF_LOSS_CYC ? ref_idle_q + 8'h01 : ref_idle_q);
      ref_ok_q <= ref_edge | (ref_ok_q & (ref_idle_q < REF_LOSS_CYC));
    end
  end

  // phase accumulator modulo the system clock rate gives exact 1200 Hz steps on average;
  // the edges carry one system clock of jitter, the price of a purely synchronous design
  assign nco_sum = {1'b0, acc_q} + {1'b0, inc_q};
  assign tog = ref_ok_q & (nco_sum >= {1'b0, NCO_MOD});

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
      inc_q <= INC_DEF;
      pclk_q <= 1'b0;
    end else if (ref_ok_q) begin
      if (tog) begin
        acc_q <= 27'(nco_sum - {1'b0, NCO_MOD});
        pclk_q <= ~pclk_q;
        inc_q <= nco_inc(fw_sel_q);
      end else begin
        acc_q <= nco_sum[26:0];
      end
    end
  end

  // status byte loads at each byte boundary of an addressed frame and shifts out on falling serial clock edges
  assign status = {ref_ok_q, fallback_q, overrun_q, filt_q[SY_IGN], 4'h0};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      miso_sh_q <= 8'h00;
      miso_fresh_q <= 1'b0;
    end else if (byte_done && ((state_q == SPCPH_ADDR && addr_hit) || state_q == SPCPH_DATA)) begin
      miso_sh_q <= status;
      miso_fresh_q <= 1'b1;
    end else if (sclk_fall && in_frame) begin
      if (miso_fresh_q) begin
        miso_fresh_q <= 1'b0; // msb must stay for the host's next rising edge
      end else begin
        miso_sh_q <= {miso_sh_q[6:0], 1'b0};
      end
    end
  end

  assign spi_miso_o = miso_sh_q[7];
  assign spi_miso_oe = (state_q == SPCPH_DATA) & in_frame; // released with select, a cycle before the state
  assign proc_clk_out = pclk_q;
  assign general_control_outputs = gcb_q;
  assign supply_keep_output = gcb_q[GCB_HOLD_BIT];
  assign ref_present = ref_ok_q;
  assign clk_fallback = fallback_q;
  assign frame_overrun = overrun_q;
  assign cfg_applied = cfg_applied_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_ref_gate: assert property (!ref_ok_q |=> $stable(proc_clk_out))
    else $error("clock output moved without reference");
  chk_inc_range: assert property (inc_q != 27'h0 && inc_q < NCO_MOD)
    else $error("nco increment outside producible range");
  chk_boot_default: assert property (!cfg_seen_q |-> inc_q == INC_DEF && fw_sel_q == FW_DEF)
    else $error("default clock not held before programming");
  chk_fallback_sel: assert property (apply_now && got_hi_q && got_lo_q && !req_ok
                                     |=> fw_sel_q == FW_DEF && clk_fallback)
    else $error("unproducible word did not fall back");
  chk_addr_gate: assert property (push_valid_q |-> $past(state_q) == SPCPH_DATA)
    else $error("byte buffered from unmatched frame");
  chk_frame_cap: assert property (push_valid_q |-> byte_cnt_q <= FRAME_MAX_BYTES && byte_cnt_q >= 5'h02)
    else $error("byte beyond frame limit buffered");
  chk_power_boot: assert property (!cfg_seen_q |-> supply_keep_output)
    else $error("power hold low before programming");
  chk_gcb_commit: assert property ($changed(gcb_q) |-> $past(apply_now) && $past(in_frame, 2) == 1'b0)
    else $error("control outputs changed outside commit");
  chk_rate_edge: assert property ($changed(inc_q) |-> $changed(proc_clk_out))
    else $error("rate changed away from a clock edge");
  chk_miso_quiet: assert property (!in_frame |-> !spi_miso_oe)
    else $error("slave data driven with select high");
  chk_commit_time: assert property ($rose(commit_pend_q) |-> ##[1:20] cfg_applied)
    else $error("commit not applied in time");

  cov_apply: cover property (cfg_applied);
  cov_fallback: cover property (cfg_applied && clk_fallback);
  cov_overrun: cover property ($rose(frame_overrun));
  cov_skip: cover property (state_q == SPCPH_SKIP && cs_rise);

endmodule
`default_nettype wire

// [dv/spcph_host_model.sv]
// spcph_host_model: serial programming host, mode 0, msb first, whole bytes only
// assumes sys_clk at 20 MHz; the serial clock runs 4 low + 4 high sys clocks (400 ns)
`timescale 1ns/1ps
`default_nettype none
module spcph_host_model (
  input wire logic sys_clk,
  input wire logic miso_wire,
  output logic sclk,
  output logic mosi,
  output logic cs_n
);
  logic [7:0] rx_q[$];

  // serial clock stands still low and select stays high between frames
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    cs_n = 1'b1;
  end

  // one frame; returns one edge after select rises so the bench can catch the commit pulse
  task automatic send_frame(input logic [7:0] b[20], input int n);
    logic [7:0] r;
    cs_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) begin
        mosi <= b[i][k];
        repeat (4) @(posedge sys_clk);
        sclk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        // latest safe point: the slave shifts only after it has seen this fall
        r[k] = miso_wire;
        sclk <= 1'b0;
      end
      rx_q.push_back(r);
    end
    repeat (6) @(posedge sys_clk);
    cs_n <= 1'b1;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// [dv/spcph_top_test.sv]
// spcph_top_test: self-checking bench of the clock and power hold block against an integer model
// assumes the host model owns the serial pins; the bench owns reference, ignition and reset
`timescale 1ns/1ps
`default_nettype none
module spcph_top_test;
  import spcph_pkg::*;
  localparam logic [7:0] ADDR = 8'h5A;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ref_clk_in = 1'b0;
  logic ref_en = 1'b0;
  logic ign_q = 1'b0;
  logic junk_q = 1'b0;
  logic sclk, mosi, cs_n, miso_o, miso_oe, miso_wire, proc_clk, supply_keep, ref_present, fallback, overrun, applied;
  logic [GCB_W-1:0] gcb;
  logic [15:0] lfsr_q = 16'h66CA;
  logic [15:0] words [7] = '{16'h1800, 16'h1801, 16'h3000, 16'h0000, 16'h8C00, 16'h208D, 16'h208E};
  int errors = 0;
  int check_count = 0;
  int exp_word = 3072;
  logic exp_fb = 1'b0;
  logic [5:0] exp_gcb = 6'h04;

  // system clock and a 16.8 MHz reference with no phase relation to it
  always #25 sys_clk = ~sys_clk;
  always #29.762 ref_clk_in = ref_en ? ~ref_clk_in : ref_clk_in;
  // a released data line shows a changing pattern so stale bits cannot pass
  always_ff @(posedge sys_clk) junk_q <= ~junk_q;
  assign miso_wire = miso_oe ? miso_o : junk_q;

  spcph_top #(.DEV_ADDR(ADDR)) u_spcph_top (.sys_clk(sys_clk), .rst(rst), .ref_clk_in(ref_clk_in),
    .spi_sclk(sclk), .spi_mosi(mosi), .shared_slave_select_n(cs_n), .ignition_off_sense(ign_q),
    .spi_miso_o(miso_o), .spi_miso_oe(miso_oe), .proc_clk_out(proc_clk), .general_control_outputs(gcb),
    .supply_keep_output(supply_keep), .ref_present(ref_present), .clk_fallback(fallback),
    .frame_overrun(overrun), .cfg_applied(applied));
  spcph_host_model u_spcph_host_model (.sys_clk(sys_clk), .miso_wire(miso_wire), .sclk(sclk), .mosi(mosi),
    .cs_n(cs_n));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // toggle counts carry one toggle of phase slack at each end of the window
  task automatic check_freq(input int got, input int exp);
    check_count++;
    if (got < exp - 2 || got > exp + 2) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // 4000 cycles at word*2400 per cycle modulo 20e6 gives word*48/100 toggles
  task automatic measure_clk(input int exp_toggles);
    int n;
    logic last;
    n = 0;
    last = proc_clk;
    repeat (4000) begin
      @(posedge sys_clk);
      #1;
      if (proc_clk !== last) n++;
      last = proc_clk;
    end
    check_freq(n, exp_toggles);
  endtask

  task automatic wait_ref();
    int k;
    k = 0;
    while (ref_present !== 1'b1 && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 100) begin
      errors++;
      stop_test();
    end
  endtask

  // one frame, then the model update and the commit, control, fallback, overrun and status comparisons
  task automatic prog(input logic [7:0] addr, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] g,
                      input int n);
    logic [7:0] fr[20];
    logic [7:0] st;
    int w;
    int k;
    bit ok;
    fr[0] = addr;
    fr[1] = hi;
    fr[2] = lo;
    fr[3] = g;
    for (int i = 4; i < 20; i++) fr[i] = 8'(i);
    st = {1'b1, exp_fb, 1'b0, ign_q, 4'h0};
    u_spcph_host_model.rx_q.delete();
    u_spcph_host_model.send_frame(fr, n);
    k = 0;
    while (applied !== 1'b1 && k < 60) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (addr == ADDR) begin
      if (k == 60) begin
        errors++;
        stop_test();
      end
      w = {hi[6:0], lo};
      ok = hi[7] == 1'b0 && w != 0 && w <= 8333 && w <= 27307;
      exp_word = ok ? w : 3072;
      exp_fb = !ok;
      exp_gcb = g[5:0];
      for (int j = 1; j < n && j < 19; j++) check_val(u_spcph_host_model.rx_q[j], st);
    end
    check_val(applied, addr == ADDR);
    check_val(gcb, exp_gcb);
    check_val(supply_keep, exp_gcb[2]);
    check_val(fallback, exp_fb);
    check_val(overrun, 1'b0);
  endtask

  // main sequence
  initial begin
    logic [15:0] r;
    repeat (8) @(posedge sys_clk);
    check_val(gcb, 6'h04);
    check_val(supply_keep, 1'b1);
    check_val(proc_clk, 1'b0);
    rst <= 1'b0;
    measure_clk(0);
    check_val(ref_present, 1'b0);
    ref_en <= 1'b1;
    wait_ref();
    measure_clk(3072 * 48 / 100);
    $display("test reset done");
    // clock words: faster clock, one step, too fast, zero, high bit set, both sides of half sys clock
    for (int i = 0; i < 7; i++) begin
      prog(ADDR, words[i][15:8], words[i][7:0], 8'h04, 4);
      measure_clk(exp_word * 48 / 100);
    end
    $display("test clock words done");
    prog(8'hA5, 8'h18, 8'h00, 8'h3B, 4);
    measure_clk(exp_word * 48 / 100);
    $display("test foreign address done");
    for (int i = 0; i < 4; i++) begin
      r = lfsr_q;
      lfsr_q = lfsr_next(lfsr_next(lfsr_q));
      prog(ADDR, r[15:8], r[7:0], lfsr_q[7:0], 4);
      measure_clk(exp_word * 48 / 100);
    end
    $display("test random words done");
    prog(ADDR, 8'h18, 8'h00, 8'h2A, 20);
    $display("test long frame done");
    @(posedge sys_clk) ign_q <= 1'b1;
    repeat (10) @(posedge sys_clk);
    prog(ADDR, 8'h18, 8'h00, 8'h00, 4); // soft turn-off by the host
    @(posedge sys_clk) ign_q <= 1'b0;
    repeat (10) @(posedge sys_clk);
    prog(ADDR, 8'h18, 8'h00, 8'h04, 4); // emergency start, host sorted the sense level, supply latched on again
    $display("test power hold done");
    ref_en <= 1'b0;
    repeat (40) @(posedge sys_clk);
    check_val(ref_present, 1'b0);
    measure_clk(0);
    ref_en <= 1'b1;
    wait_ref();
    measure_clk(exp_word * 48 / 100);
    $display("test reference loss done");
    stop_test();
  end
endmodule
`default_nettype wire
